//--- afm_fault_mgr.sv
// Purpose: warning, fault and alarm manager of the gas analyzer
// Assumes: measurement inputs are stable while I_CYCLE_DONE pulses
// Notes:   general and validation relays and flags latch; assignable relay follows its flag; pulses last one clock
// Function
// R01: Post every warning, alarm and fault to display and serial link.
// R02: Restart with fresh dryer cycle after three consecutive warnings.
// R03: Escalate a warning to its fault after more than five restarts.
// R04: Warn when wet/dry DC, pressure or temperature delta is out of range.
// R05: Warn on peak tracking or ramp adjustment correction.
// R06: Warn when dry cycle cell pressure is out of range.
// R07: Warn on bad fit, negative signal, second or third reference.
// R08: Skip daily permeation validation on high concentration and warn.
// R09: Drive general fault, assignable and validation fail relays.
// R10: System faults latch general relay and loop response until reset.
// R11: Count restarts per restart-causing warning, each with its own fault.
// R12: Negative signal fault stops its restarts and latches until reset.
// R13: Flow switch fault when enabled input shows alarm.
// R14: Laser current low or high fault outside its limits.
// R15: Laser power faults on saturated or weak DC signal.
// R16: Zero low or high fault with laser off.
// R17: Cell pressure and temperature high and low faults.
// R18: Heated enclosure off set point by over 5 degC raises temperature fault.
// R19: Validation 1 or 2 failure holds relay until cancelled.
// R20: Low purge rate and new scrubber faults.
// R21: Concentration high and low user alarms against setpoints.
// R22: One bit per alarm in a 32-bit historical flag word.
// R23: Historical flags stay until alarm reset.
// R24: A new validation start clears validation fail alarms.
// R25: A cycle without a warning clears its counters.
`timescale 1ns/1ns
`default_nettype none
`include "afm_params.svh"
module afm_fault_mgr (
	input  wire logic                  I_REF_CLK,
	input  wire logic                  I_RST,
	input  wire logic                  I_CYCLE_DONE,
	input  wire afm_pkg::afm_meas_t    I_WET_DC,
	input  wire afm_pkg::afm_meas_t    I_DRY_DC,
	input  wire afm_pkg::afm_meas_t    I_DC_LIM,
	input  wire afm_pkg::afm_meas_t    I_WET_PRESS,
	input  wire afm_pkg::afm_meas_t    I_DRY_PRESS,
	input  wire afm_pkg::afm_meas_t    I_DP_LIM,
	input  wire afm_pkg::afm_meas_t    I_WET_TEMP,
	input  wire afm_pkg::afm_meas_t    I_DRY_TEMP,
	input  wire afm_pkg::afm_meas_t    I_DT_LIM,
	input  wire afm_pkg::afm_meas_t    I_DRYP_MIN,
	input  wire afm_pkg::afm_meas_t    I_DRYP_MAX,
	input  wire logic                  I_PEAK_CORR,
	input  wire logic                  I_RAMP_CORR,
	input  wire logic                  I_FIT_BAD,
	input  wire logic                  I_REF2_BAD,
	input  wire logic                  I_REF3_BAD,
	input  wire logic                  I_CONC_BELOW_RANGE,
	input  wire afm_pkg::afm_meas_t    I_LASER_CURR,
	input  wire afm_pkg::afm_meas_t    I_LCURR_MIN,
	input  wire afm_pkg::afm_meas_t    I_LCURR_MAX,
	input  wire logic                  I_DC_SATURATED,
	input  wire logic                  I_DC_WEAK,
	input  wire logic                  I_LASER_OFF,
	input  wire afm_pkg::afm_meas_t    I_ZERO_SIG,
	input  wire afm_pkg::afm_meas_t    I_ZERO_MIN,
	input  wire afm_pkg::afm_meas_t    I_ZERO_MAX,
	input  wire afm_pkg::afm_meas_t    I_CELL_PRESS,
	input  wire afm_pkg::afm_meas_t    I_PRESS_MIN,
	input  wire afm_pkg::afm_meas_t    I_PRESS_MAX,
	input  wire afm_pkg::afm_meas_t    I_CELL_TEMP,
	input  wire afm_pkg::afm_meas_t    I_TEMP_MIN,
	input  wire afm_pkg::afm_meas_t    I_TEMP_MAX,
	input  wire logic                  I_HEATED,
	input  wire afm_pkg::afm_meas_t    I_ENCL_TEMP,
	input  wire afm_pkg::afm_meas_t    I_ENCL_SETPT,
	input  wire logic                  I_FLOW_DI_EN,
	input  wire logic                  I_FLOW_DI,
	input  wire logic                  I_LOW_PURGE,
	input  wire logic                  I_NEW_SCRUB,
	input  wire afm_pkg::afm_meas_t    I_CONC,
	input  wire afm_pkg::afm_meas_t    I_CONC_HI_SP,
	input  wire afm_pkg::afm_meas_t    I_CONC_LO_SP,
	input  wire logic                  I_GEN_ALARM_RESET,
	input  wire afm_pkg::afm_loop_t    I_LOOP_FAULT_RESPONSE,
	input  wire logic [4:0]            I_ASSIGN_SEL,
	input  wire logic                  I_VAL_START,
	input  wire afm_pkg::afm_val_src_t I_VAL_SRC,
	input  wire logic                  I_PERM_SYSTEM,
	input  wire logic                  I_DAILY_VAL_EN,
	input  wire afm_pkg::afm_meas_t    I_VAL_CONC_LIM,
	input  wire logic                  I_VAL1_FAIL,
	input  wire logic                  I_VAL2_FAIL,
	input  wire logic                  I_CANCEL_VAL_ALARMS,
	output logic [`AFM_WOUT_W-1:0]     O_WARNINGS,
	output logic                       O_RESTART,
	output logic [31:0]                O_HIST_FLAGS,
	output logic                       O_GEN_FAULT_RELAY,
	output logic                       O_ASSIGN_RELAY,
	output logic                       O_VAL_FAIL_RELAY,
	output afm_pkg::afm_loop_t         O_LOOP_FAULT_RESPONSE,
	output logic                       O_VAL_GRANT,
	output logic                       O_VAL_SKIP,
	output logic [5:0]                 O_EVENT_CODE,
	output logic                       O_DISP_POST,
	output logic                       O_SERIAL_POST
);
	function automatic logic delta_over(input afm_pkg::afm_meas_t a,
		input afm_pkg::afm_meas_t b, input afm_pkg::afm_meas_t lim);
		return ((a > b) ? a - b : b - a) > lim;
	endfunction : delta_over

	function automatic logic [5:0] first_set(
		input logic [`AFM_EV_W-1:0] v);
		logic [5:0] idx;
		idx = 6'h00;
		for (int i = `AFM_EV_W - 1; i >= 0; i--) begin
			if (v[i]) idx = 6'(i);
		end
		return idx;
	endfunction : first_set

	afm_warn_if wi ();

	afm_restart_cnt u_cnt (
		.i_clk (I_REF_CLK),
		.i_rst (I_RST),
		.wi    (wi)
	);

	afm_pkg::afm_warn_t        warn_now;
	logic [31:0]               fv;
	logic [`AFM_WOUT_W-1:0]    warn_r;
	logic [`AFM_WOUT_W-1:0]    warn_nxt;
	logic [31:0]               fv_r;
	logic [31:0]               hist_r;
	logic [31:0]               hist_nxt;
	logic [31:0]               sticky;
	logic                      gen_r;
	logic                      gen_nxt;
	afm_pkg::afm_loop_t        loop_r;
	logic                      assign_r;
	logic                      val1_r;
	logic                      val2_r;
	logic                      val1_nxt;
	logic                      val2_nxt;
	logic                      vrelay_r;
	logic                      grant_r;
	logic                      skip_r;
	logic [`AFM_EV_W-1:0]      ev_now;
	logic [`AFM_EV_W-1:0]      ev_prev_r;
	logic [`AFM_EV_W-1:0]      pend_r;
	logic [`AFM_EV_W-1:0]      pend_nxt;
	logic [`AFM_EV_W-1:0]      served;
	logic [5:0]                code_r;
	logic                      post_r;
	wire                       encl_dev;
	wire                       skip;
	wire                       grant;
	wire                       sys_fault;
	wire afm_pkg::afm_warn_t   rf;

	// R04 wet against dry
	assign warn_now[`AFM_W_DC]     = delta_over(I_WET_DC, I_DRY_DC,
		I_DC_LIM);
	assign warn_now[`AFM_W_PDELTA] = delta_over(I_WET_PRESS,
		I_DRY_PRESS, I_DP_LIM);
	assign warn_now[`AFM_W_TEMP]   = delta_over(I_WET_TEMP, I_DRY_TEMP,
		I_DT_LIM);
	// R06 dryer may clog
	assign warn_now[`AFM_W_DRYP]   = (I_DRY_PRESS < I_DRYP_MIN) |
		(I_DRY_PRESS > I_DRYP_MAX);
	// R05 correction applied
	assign warn_now[`AFM_W_PEAK]   = I_PEAK_CORR;
	assign warn_now[`AFM_W_RAMP]   = I_RAMP_CORR;
	// R07 fit and references
	assign warn_now[`AFM_W_FIT]    = I_FIT_BAD;
	assign warn_now[`AFM_W_NEG]    = I_CONC_BELOW_RANGE;
	assign warn_now[`AFM_W_REF2]   = I_REF2_BAD;
	assign warn_now[`AFM_W_REF3]   = I_REF3_BAD;

	assign wi.cycle_done = I_CYCLE_DONE;
	assign wi.warn       = warn_now;
	assign wi.clear      = I_GEN_ALARM_RESET;
	// Reset clears restart faults in its own cycle, not one later
	assign rf            = wi.fault & ~{`AFM_NUM_WARN{I_GEN_ALARM_RESET}};

	// R08 protect the dryer
	assign skip  = I_VAL_START & (I_VAL_SRC == afm_pkg::VS_DAILY) &
		I_PERM_SYSTEM & I_DAILY_VAL_EN & (I_CONC > I_VAL_CONC_LIM);
	assign grant = I_VAL_START & ~skip;

	// Unable flag holds until the next finished cycle
	assign warn_nxt[`AFM_W_UNABLE] = skip |
		(warn_r[`AFM_W_UNABLE] & ~I_CYCLE_DONE);
	assign warn_nxt[`AFM_NUM_WARN-1:0] = I_CYCLE_DONE ? warn_now :
		warn_r[`AFM_NUM_WARN-1:0];

	// R18 enclosure deviation
	assign encl_dev = I_HEATED &
		delta_over(I_ENCL_TEMP, I_ENCL_SETPT, `AFM_ENCL_DEV);

	assign fv[`AFM_HF_GEN_PAST]  = 1'b0;
	assign fv[`AFM_HF_GEN_NOW]   = 1'b0;
	// R15 DC signal level
	assign fv[`AFM_HF_LP_LOW]    = I_DC_WEAK;
	assign fv[`AFM_HF_LP_HIGH]   = I_DC_SATURATED;
	// R16 dark detector level
	assign fv[`AFM_HF_ZERO_LOW]  = I_LASER_OFF & (I_ZERO_SIG < I_ZERO_MIN);
	assign fv[`AFM_HF_ZERO_HIGH] = I_LASER_OFF & (I_ZERO_SIG > I_ZERO_MAX);
	// R14 laser current limits
	assign fv[`AFM_HF_LC_LOW]    = I_LASER_CURR < I_LCURR_MIN;
	assign fv[`AFM_HF_LC_HIGH]   = I_LASER_CURR > I_LCURR_MAX;
	// R17 cell operating limits
	assign fv[`AFM_HF_P_LOW]     = I_CELL_PRESS < I_PRESS_MIN;
	assign fv[`AFM_HF_P_HIGH]    = I_CELL_PRESS > I_PRESS_MAX;
	// R18 enclosure joins temperature
	assign fv[`AFM_HF_T_LOW]     = (I_CELL_TEMP < I_TEMP_MIN) |
		(encl_dev & (I_ENCL_TEMP < I_ENCL_SETPT));
	assign fv[`AFM_HF_T_HIGH]    = (I_CELL_TEMP > I_TEMP_MAX) |
		(encl_dev & (I_ENCL_TEMP > I_ENCL_SETPT));
	// R21 user setpoints
	assign fv[`AFM_HF_CONC_LOW]  = I_CONC < I_CONC_LO_SP;
	assign fv[`AFM_HF_CONC_HIGH] = I_CONC > I_CONC_HI_SP;
	// R11 restart faults mapped
	assign fv[`AFM_HF_PEAK_RS]   = rf[`AFM_W_PEAK];
	assign fv[`AFM_HF_FIT_RS]    = rf[`AFM_W_FIT];
	assign fv[`AFM_HF_RAMP_RS]   = rf[`AFM_W_RAMP];
	assign fv[18:17]             = 2'h0;
	// R13 flow switch
	assign fv[`AFM_HF_FLOW]      = I_FLOW_DI_EN & I_FLOW_DI;
	assign fv[`AFM_HF_VAL1]      = val1_r;
	assign fv[`AFM_HF_VAL2]      = val2_r;
	assign fv[22]                = 1'b0;
	assign fv[`AFM_HF_NEG_RS]    = rf[`AFM_W_NEG];
	assign fv[`AFM_HF_DC_RS]     = rf[`AFM_W_DC];
	assign fv[`AFM_HF_TEMP_RS]   = rf[`AFM_W_TEMP];
	assign fv[`AFM_HF_DRYP_RS]   = rf[`AFM_W_DRYP];
	// R20 dryer health
	assign fv[`AFM_HF_NEW_SCRUB] = I_NEW_SCRUB;
	assign fv[`AFM_HF_REF2_RS]   = rf[`AFM_W_REF2];
	assign fv[`AFM_HF_REF3_RS]   = rf[`AFM_W_REF3];
	assign fv[`AFM_HF_PDELTA_RS] = rf[`AFM_W_PDELTA];
	assign fv[`AFM_HF_LOW_PURGE] = I_LOW_PURGE;

	// R10 latch until reset
	assign sys_fault = |(fv & `AFM_SYS_MASK);
	assign gen_nxt   = sys_fault | (gen_r & ~I_GEN_ALARM_RESET);

	// R19 set wins over cancel
	assign val1_nxt = I_VAL1_FAIL |
		(val1_r & ~I_CANCEL_VAL_ALARMS & ~grant);
	// R24 new run decides
	assign val2_nxt = I_VAL2_FAIL |
		(val2_r & ~I_CANCEL_VAL_ALARMS & ~grant);

	// R23 hold until reset
	assign sticky = (hist_r & ~{32{I_GEN_ALARM_RESET}}) | fv |
		{31'h0, gen_nxt};
	// R22 one bit each
	assign hist_nxt = {sticky[31:`AFM_HF_GEN_NOW+1], |fv,
		sticky[`AFM_HF_GEN_PAST]};

	// R01 edges become events
	assign ev_now   = {warn_r, fv_r};
	assign served   = pend_r & (~pend_r + `AFM_EV_W'(1));
	assign pend_nxt = (pend_r & ~served) | (ev_now & ~ev_prev_r);

	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			warn_r <= '0;
			fv_r   <= 32'h0;
			hist_r <= 32'h0;
			gen_r  <= 1'b0;
			loop_r <= `AFM_LOOP_NORMAL;
		end else begin
			warn_r <= warn_nxt;
			fv_r   <= fv;
			hist_r <= hist_nxt;
			gen_r  <= gen_nxt;
			loop_r <= gen_nxt ? I_LOOP_FAULT_RESPONSE : `AFM_LOOP_NORMAL;
		end
	end

	// R09 assignable and validation relays
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			assign_r <= 1'b0;
			val1_r   <= 1'b0;
			val2_r   <= 1'b0;
			vrelay_r <= 1'b0;
			grant_r  <= 1'b0;
			skip_r   <= 1'b0;
		end else begin
			assign_r <= fv[I_ASSIGN_SEL];
			val1_r   <= val1_nxt;
			val2_r   <= val2_nxt;
			vrelay_r <= val1_nxt | val2_nxt;
			grant_r  <= grant;
			skip_r   <= skip;
		end
	end

	// Lowest index first; a burst drains one per clock
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			ev_prev_r <= '0;
			pend_r    <= '0;
			code_r    <= 6'h00;
			post_r    <= 1'b0;
		end else begin
			ev_prev_r <= ev_now;
			pend_r    <= pend_nxt;
			code_r    <= first_set(pend_r);
			post_r    <= |pend_r;
		end
	end

	assign O_WARNINGS            = warn_r;
	assign O_RESTART             = wi.restart;
	assign O_HIST_FLAGS          = hist_r;
	assign O_GEN_FAULT_RELAY     = gen_r;
	assign O_ASSIGN_RELAY        = assign_r;
	assign O_VAL_FAIL_RELAY      = vrelay_r;
	assign O_LOOP_FAULT_RESPONSE = loop_r;
	assign O_VAL_GRANT           = grant_r;
	assign O_VAL_SKIP            = skip_r;
	assign O_EVENT_CODE          = code_r;
	assign O_DISP_POST           = post_r;
	assign O_SERIAL_POST         = post_r;

	gen_set_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // R10
		sys_fault |=> O_GEN_FAULT_RELAY)
		else $error("system fault missed general relay");
	gen_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // R10
		(O_GEN_FAULT_RELAY && !I_GEN_ALARM_RESET) |=> O_GEN_FAULT_RELAY)
		else $error("general relay dropped without reset");
	loop_follow_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // R10
		O_GEN_FAULT_RELAY |-> O_LOOP_FAULT_RESPONSE ==
		$past(I_LOOP_FAULT_RESPONSE))
		else $error("loop response not the configured option");
	val_skip_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // R08
		skip |=> (O_VAL_SKIP && !O_VAL_GRANT &&
		O_WARNINGS[`AFM_W_UNABLE]))
		else $error("daily validation not skipped");
	val_clear_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // R24
		(grant && !I_VAL1_FAIL && !I_VAL2_FAIL) |=> !O_VAL_FAIL_RELAY)
		else $error("validation start left fail relay");
	val_hold_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // R19
		(I_VAL1_FAIL ##1 (!I_CANCEL_VAL_ALARMS && !grant)[*2])
		|=> O_VAL_FAIL_RELAY)
		else $error("validation fail relay not held");
	hist_keep_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // R23
		(O_HIST_FLAGS[`AFM_HF_P_LOW] && !I_GEN_ALARM_RESET)
		|=> O_HIST_FLAGS[`AFM_HF_P_LOW])
		else $error("historical flag lost before reset");
	post_both_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // R01
		(fv[`AFM_HF_P_LOW] && !fv_r[`AFM_HF_P_LOW]) |-> ##[1:45]
		(O_DISP_POST && O_SERIAL_POST &&
		O_EVENT_CODE == 6'(`AFM_HF_P_LOW)))
		else $error("fault event was not posted");
	delta_warn_a: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // R04
		(I_CYCLE_DONE && delta_over(I_WET_DC, I_DRY_DC, I_DC_LIM))
		|=> O_WARNINGS[`AFM_W_DC])
		else $error("DC delta warning not raised");
endmodule : afm_fault_mgr
`default_nettype wire

//--- afm_panel_model.sv
// Purpose: operator panel and serial receiver model
// Assumes: posts are one clock long
// Notes:   counts posts and flags display/serial disagreement
`timescale 1ns/1ns
`default_nettype none
module afm_panel_model (
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_disp,
	input  wire logic               i_serial,
	input  wire logic [5:0]         i_code,
	output logic [5:0]              o_last_code,
	output logic [7:0]              o_posts,
	output logic [7:0]              o_bad
);
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_last_code <= 6'h00;
			o_posts <= 8'h00;
			o_bad <= 8'h00;
		end else begin
			if (i_disp !== i_serial)
				o_bad <= o_bad + 8'h01;
			if (i_disp === 1'b1) begin
				o_last_code <= i_code;
				o_posts <= o_posts + 8'h01;
			end
		end
	end
endmodule : afm_panel_model
`default_nettype wire

//--- afm_params.svh
// Purpose: shared constants for the analyzer fault manager
// Assumes: included by the package, the fault manager, the restart counter and the bench
// Notes:   flag positions match the displayed hexadecimal code
`ifndef AFM_PARAMS_SVH
`define AFM_PARAMS_SVH

`define AFM_MEAS_W        16
`define AFM_NUM_WARN      10
`define AFM_WOUT_W        11
`define AFM_EV_W          43
`define AFM_INST_COUNT    3
`define AFM_RESTART_LIMIT 3'h5
// 5.0 degC expressed in 0.1 degC steps
`define AFM_ENCL_DEV      16'h0032
`define AFM_LOOP_NORMAL   2'h0
// System faults only: no user, validation or unused bits
`define AFM_SYS_MASK      32'hFF89CFFC

// Warning indices: 0 to 9 restart-causing, 10 unable to validate
`define AFM_W_DC          0
`define AFM_W_TEMP        1
`define AFM_W_DRYP        2
`define AFM_W_FIT         3
`define AFM_W_PEAK        4
`define AFM_W_RAMP        5
`define AFM_W_PDELTA      6
`define AFM_W_REF2        7
`define AFM_W_REF3        8
`define AFM_W_NEG         9
`define AFM_W_UNABLE      10

// Historical flag word bit positions
`define AFM_HF_GEN_PAST   0
`define AFM_HF_GEN_NOW    1
`define AFM_HF_LP_LOW     2
`define AFM_HF_LP_HIGH    3
`define AFM_HF_ZERO_LOW   4
`define AFM_HF_ZERO_HIGH  5
`define AFM_HF_LC_LOW     6
`define AFM_HF_LC_HIGH    7
`define AFM_HF_P_LOW      8
`define AFM_HF_P_HIGH     9
`define AFM_HF_T_LOW      10
`define AFM_HF_T_HIGH     11
`define AFM_HF_CONC_LOW   12
`define AFM_HF_CONC_HIGH  13
`define AFM_HF_PEAK_RS    14
`define AFM_HF_FIT_RS     15
`define AFM_HF_RAMP_RS    16
`define AFM_HF_FLOW       19
`define AFM_HF_VAL1       20
`define AFM_HF_VAL2       21
`define AFM_HF_NEG_RS     23
`define AFM_HF_DC_RS      24
`define AFM_HF_TEMP_RS    25
`define AFM_HF_DRYP_RS    26
`define AFM_HF_NEW_SCRUB  27
`define AFM_HF_REF2_RS    28
`define AFM_HF_REF3_RS    29
`define AFM_HF_PDELTA_RS  30
`define AFM_HF_LOW_PURGE  31

`endif

//--- afm_pkg.sv
// Purpose: types for the analyzer fault manager
// Assumes: afm_params.svh holds the numeric constants
// Notes:   validation sources are one-hot
`include "afm_params.svh"
package afm_pkg;
	typedef logic [`AFM_MEAS_W-1:0]   afm_meas_t;
	typedef logic [`AFM_NUM_WARN-1:0] afm_warn_t;
	typedef logic [1:0]               afm_loop_t;
	typedef enum logic [3:0] {
		VS_DAILY  = 4'h1,
		VS_DI     = 4'h2,
		VS_MANUAL = 4'h4,
		VS_PARAM  = 4'h8
	} afm_val_src_t;
endpackage : afm_pkg

//--- afm_restart_cnt.sv
// Purpose: per-warning instance and restart counting
// Assumes: warn is valid in the cycle_done cycle
// Notes:   escalated faults latch until clear
`timescale 1ns/1ns
`default_nettype none
`include "afm_params.svh"
module afm_restart_cnt (
	input  wire logic i_clk,
	input  wire logic i_rst,
	afm_warn_if.cnt   wi
);
	afm_pkg::afm_warn_t fire;
	afm_pkg::afm_warn_t fault;
	logic               restart_r;

	genvar gi;
	generate
	for (gi = 0; gi < `AFM_NUM_WARN; gi++) begin : g_w
		logic [1:0] inst_r;
		logic [1:0] inst_nxt;
		logic [2:0] rcnt_r;
		logic [2:0] rcnt_nxt;
		logic       fault_r;
		logic       fault_nxt;
		wire        hit   = wi.cycle_done & wi.warn[gi];
		wire        clean = wi.cycle_done & ~wi.warn[gi];
		// R12 suppress negative restarts
		wire        supp  = (gi == `AFM_W_NEG) & fault_r;
		wire        count = hit & ~supp;
		// R02 restart on third
		wire        fire_w = count &
			(inst_r == 2'(`AFM_INST_COUNT - 1));
		// R03 escalate past limit
		wire        esc = fire_w & (rcnt_r == `AFM_RESTART_LIMIT);

		// R25 quiet cycle clears
		assign inst_nxt = (clean | fire_w) ? 2'h0 :
			count ? inst_r + 2'h1 : inst_r;
		assign rcnt_nxt = clean ? 3'h0 :
			(fire_w & ~esc) ? rcnt_r + 3'h1 : rcnt_r;
		// R12 latch until reset
		assign fault_nxt = esc | (fault_r & ~wi.clear);
		assign fire[gi]  = fire_w;
		// R11 one fault each
		assign fault[gi] = fault_r;

		always_ff @(posedge i_clk or posedge i_rst) begin
			if (i_rst) begin
				inst_r  <= 2'h0;
				rcnt_r  <= 3'h0;
				fault_r <= 1'b0;
			end else begin
				inst_r  <= inst_nxt;
				rcnt_r  <= rcnt_nxt;
				fault_r <= fault_nxt;
			end
		end

		restart_third_a: assert property (@(posedge i_clk) // R02
			disable iff (i_rst)
			(hit && !supp && inst_r == 2'(`AFM_INST_COUNT - 1)) |=> restart_r)
			else $error("third instance gave no restart");
		fault_esc_a: assert property (@(posedge i_clk) // R03
			disable iff (i_rst)
			(fire_w && rcnt_r == `AFM_RESTART_LIMIT) |=> fault_r)
			else $error("restart limit did not escalate");
		neg_supp_a: assert property (@(posedge i_clk) // R12
			disable iff (i_rst)
			(supp && !wi.clear) |=> (fault_r && inst_r == 2'h0))
			else $error("suppressed warning still counted");
	end
	endgenerate

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			restart_r <= 1'b0;
		end else begin
			restart_r <= |fire;
		end
	end

	assign wi.restart = restart_r;
	assign wi.fault   = fault;
endmodule : afm_restart_cnt
`default_nettype wire

//--- afm_warn_if.sv
// Purpose: carrier between fault manager and restart counters
// Assumes: one clock domain
// Notes:   restart and fault come from flip-flops
`timescale 1ns/1ns
`default_nettype none
interface afm_warn_if;
	logic               cycle_done;
	afm_pkg::afm_warn_t warn;
	logic               clear;
	logic               restart;
	afm_pkg::afm_warn_t fault;
	modport mgr (output cycle_done, output warn, output clear,
		input restart, input fault);
	modport cnt (input cycle_done, input warn, input clear,
		output restart, output fault);
endinterface : afm_warn_if
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench for the analyzer fault manager
// Assumes: outputs settle 1 ns after the clock edge
// Notes:   inputs change by non-blocking assignment on the edge
`timescale 1ns/1ns
`default_nettype none
`include "afm_params.svh"
module tb_top;
	logic I_REF_CLK, I_RST, I_CYCLE_DONE, I_PEAK_CORR, I_RAMP_CORR, I_FIT_BAD;
	logic I_REF2_BAD, I_REF3_BAD, I_CONC_BELOW_RANGE, I_DC_SATURATED;
	logic I_DC_WEAK, I_LASER_OFF, I_HEATED, I_FLOW_DI_EN, I_FLOW_DI;
	logic I_LOW_PURGE, I_NEW_SCRUB, I_GEN_ALARM_RESET, I_VAL_START;
	logic I_PERM_SYSTEM, I_DAILY_VAL_EN, I_VAL1_FAIL, I_VAL2_FAIL;
	logic I_CANCEL_VAL_ALARMS;
	afm_pkg::afm_meas_t I_WET_DC, I_DRY_DC, I_DC_LIM, I_WET_PRESS, I_DRY_PRESS;
	afm_pkg::afm_meas_t I_DP_LIM, I_WET_TEMP, I_DRY_TEMP, I_DT_LIM, I_DRYP_MIN;
	afm_pkg::afm_meas_t I_DRYP_MAX, I_LASER_CURR, I_LCURR_MIN, I_LCURR_MAX;
	afm_pkg::afm_meas_t I_ZERO_SIG, I_ZERO_MIN, I_ZERO_MAX, I_CELL_PRESS;
	afm_pkg::afm_meas_t I_PRESS_MIN, I_PRESS_MAX, I_CELL_TEMP, I_TEMP_MIN;
	afm_pkg::afm_meas_t I_TEMP_MAX, I_ENCL_TEMP, I_ENCL_SETPT, I_CONC;
	afm_pkg::afm_meas_t I_CONC_HI_SP, I_CONC_LO_SP, I_VAL_CONC_LIM;
	afm_pkg::afm_loop_t I_LOOP_FAULT_RESPONSE, O_LOOP_FAULT_RESPONSE;
	afm_pkg::afm_val_src_t I_VAL_SRC;
	logic [4:0] I_ASSIGN_SEL;
	logic [`AFM_WOUT_W-1:0] O_WARNINGS;
	logic [31:0] O_HIST_FLAGS;
	logic [5:0] O_EVENT_CODE, last_code;
	logic O_RESTART, O_GEN_FAULT_RELAY, O_ASSIGN_RELAY, O_VAL_FAIL_RELAY;
	logic O_VAL_GRANT, O_VAL_SKIP, O_DISP_POST, O_SERIAL_POST;
	logic [7:0] posts, bad;
	int error_cnt, compares, restarts;

	afm_fault_mgr DUT (.*);
	afm_panel_model panel (.i_clk(I_REF_CLK), .i_rst(I_RST),
		.i_disp(O_DISP_POST), .i_serial(O_SERIAL_POST), .i_code(O_EVENT_CODE),
		.o_last_code(last_code), .o_posts(posts), .o_bad(bad));

	initial begin
		I_REF_CLK = 1'b0;
		forever #25 I_REF_CLK = ~I_REF_CLK;
	end

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// One-clock request pulse; returns 1 ns after the taking edge
	task pulse(input int sel);
		@(posedge I_REF_CLK);
		case (sel)
			0: I_CYCLE_DONE <= 1'b1;
			1: I_GEN_ALARM_RESET <= 1'b1;
			2: I_VAL_START <= 1'b1;
			3: I_VAL1_FAIL <= 1'b1;
			default: I_CANCEL_VAL_ALARMS <= 1'b1;
		endcase
		@(posedge I_REF_CLK);
		{I_CYCLE_DONE, I_GEN_ALARM_RESET, I_VAL_START} <= 3'h0;
		{I_VAL1_FAIL, I_CANCEL_VAL_ALARMS} <= 2'h0;
		#1;
	endtask : pulse

	task report_and_stop;
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	initial begin
		#100000;
		error_cnt++;
		report_and_stop;
	end

	initial begin
		error_cnt = 0;
		compares = 0;
		restarts = 0;
		I_RST = 1'b1;
		{I_CYCLE_DONE, I_PEAK_CORR, I_RAMP_CORR, I_FIT_BAD, I_REF2_BAD} = '0;
		{I_REF3_BAD, I_CONC_BELOW_RANGE, I_DC_SATURATED, I_DC_WEAK} = '0;
		{I_LASER_OFF, I_HEATED, I_FLOW_DI_EN, I_FLOW_DI, I_LOW_PURGE} = '0;
		{I_NEW_SCRUB, I_GEN_ALARM_RESET, I_VAL_START, I_PERM_SYSTEM} = '0;
		{I_DAILY_VAL_EN, I_VAL1_FAIL, I_VAL2_FAIL, I_CANCEL_VAL_ALARMS} = '0;
		{I_WET_DC, I_DRY_DC, I_DC_LIM, I_WET_PRESS, I_DRY_PRESS, I_DP_LIM,
			I_WET_TEMP, I_DRY_TEMP, I_DT_LIM, I_DRYP_MIN, I_DRYP_MAX,
			I_LASER_CURR, I_LCURR_MIN, I_LCURR_MAX, I_ZERO_SIG, I_ZERO_MIN,
			I_ZERO_MAX, I_CELL_PRESS, I_PRESS_MIN, I_PRESS_MAX, I_CELL_TEMP,
			I_TEMP_MIN, I_TEMP_MAX, I_ENCL_TEMP, I_ENCL_SETPT, I_CONC,
			I_CONC_HI_SP, I_CONC_LO_SP, I_VAL_CONC_LIM} = {29{16'h0100}};
		// Windows wide open so nothing trips by default
		{I_DRYP_MIN, I_LCURR_MIN, I_ZERO_MIN, I_PRESS_MIN, I_TEMP_MIN} = '0;
		{I_DC_LIM, I_DP_LIM, I_DT_LIM, I_DRYP_MAX, I_LCURR_MAX} = '1;
		{I_ZERO_MAX, I_PRESS_MAX, I_TEMP_MAX, I_CONC_HI_SP} = '1;
		I_CONC_LO_SP = 16'h0000;
		I_VAL_CONC_LIM = 16'h0050;
		I_VAL_SRC = afm_pkg::VS_DI;
		I_LOOP_FAULT_RESPONSE = 2'h2;
		I_ASSIGN_SEL = 5'h08;
		repeat (8) @(posedge I_REF_CLK);
		I_RST <= 1'b0;
		#1;
		chk("hist after reset", O_HIST_FLAGS, 32'h0);
		// Pressure low fault, refused reset, then clear
		@(posedge I_REF_CLK) I_PRESS_MIN <= 16'h0200;
		repeat (2) @(posedge I_REF_CLK);
		#1;
		chk("hist press low", O_HIST_FLAGS, 32'h00000103);
		chk("gen relay", O_GEN_FAULT_RELAY, 1'b1);
		chk("loop resp", O_LOOP_FAULT_RESPONSE, 2'h2);
		chk("assign relay", O_ASSIGN_RELAY, 1'b1);
		pulse(1);
		chk("relay held", O_GEN_FAULT_RELAY, 1'b1);
		@(posedge I_REF_CLK) I_PRESS_MIN <= 16'h0000;
		repeat (4) @(posedge I_REF_CLK);
		#1;
		chk("flag kept", O_HIST_FLAGS[8], 1'b1);
		chk("event code", last_code, 6'h08);
		chk("post mismatch", bad, 8'h00);
		chk("post count", posts, 8'h01);
		pulse(1);
		chk("relay cleared", O_GEN_FAULT_RELAY, 1'b0);
		chk("loop normal", O_LOOP_FAULT_RESPONSE, 2'h0);
		// Peak and negative warnings: restart every third, sixth escalates
		@(posedge I_REF_CLK) {I_PEAK_CORR, I_CONC_BELOW_RANGE} <= 2'h3;
		for (int i = 0; i < 18; i++) begin
			pulse(0);
			chk("restart", O_RESTART, (i % 3 == 2));
			restarts += int'(O_RESTART === 1'b1);
		end
		chk("restart count", restarts, 6);
		chk("peak warn", O_WARNINGS[4], 1'b1);
		@(posedge I_REF_CLK) I_PEAK_CORR <= 1'b0;
		repeat (2) @(posedge I_REF_CLK);
		#1;
		chk("peak fault", O_HIST_FLAGS[14], 1'b1);
		chk("neg fault", O_HIST_FLAGS[23], 1'b1);
		pulse(0);
		chk("warn gone", O_WARNINGS[4], 1'b0);
		chk("neg warn", O_WARNINGS[9], 1'b1);
		for (int i = 0; i < 3; i++) begin
			pulse(0);
			chk("neg quiet", O_RESTART, 1'b0);
		end
		@(posedge I_REF_CLK) I_CONC_BELOW_RANGE <= 1'b0;
		pulse(1);
		chk("peak fault clr", O_HIST_FLAGS[14], 1'b0);
		chk("gen relay clr", O_GEN_FAULT_RELAY, 1'b0);
		// Validation failure, cancel, daily skip and exempt source
		pulse(3);
		chk("val relay", O_VAL_FAIL_RELAY, 1'b1);
		pulse(4);
		chk("val cancel", O_VAL_FAIL_RELAY, 1'b0);
		pulse(3);
		pulse(2);
		chk("val grant", O_VAL_GRANT, 1'b1);
		chk("val restart clr", O_VAL_FAIL_RELAY, 1'b0);
		@(posedge I_REF_CLK);
		{I_PERM_SYSTEM, I_DAILY_VAL_EN} <= 2'h3;
		I_VAL_SRC <= afm_pkg::VS_DAILY;
		pulse(2);
		chk("val skip", O_VAL_SKIP, 1'b1);
		@(posedge I_REF_CLK);
		#1;
		chk("unable warn", O_WARNINGS[10], 1'b1);
		@(posedge I_REF_CLK) I_VAL_SRC <= afm_pkg::VS_MANUAL;
		pulse(2);
		chk("val exempt", O_VAL_GRANT, 1'b1);
		// Mixed faults, DC delta warning, flow switch on the relay
		@(posedge I_REF_CLK);
		{I_FLOW_DI_EN, I_FLOW_DI, I_LASER_OFF, I_HEATED} <= 4'hF;
		{I_LOW_PURGE, I_DC_SATURATED, I_NEW_SCRUB} <= 3'h7;
		I_WET_DC <= 16'h0200;
		I_DC_LIM <= 16'h0010;
		I_ZERO_MIN <= 16'h0200;
		I_ENCL_SETPT <= 16'h0140;
		I_CONC_HI_SP <= 16'h0080;
		I_LCURR_MAX <= 16'h0080;
		I_ASSIGN_SEL <= 5'h13;
		pulse(0);
		chk("dc warn", O_WARNINGS, 32'h001);
		chk("fault mix", O_HIST_FLAGS, 32'h8818249B);
		chk("assign flow", O_ASSIGN_RELAY, 1'b1);
		chk("encl gen", O_GEN_FAULT_RELAY, 1'b1);
		report_and_stop;
	end
endmodule : tb_top
`default_nettype wire
